// *** ffs_pkg.sv ***
// constants and types shared by the fifo status flag block
`default_nettype none
package ffs_pkg;
    localparam int DATA_W = 9;
    localparam int OFS_W = 12;
    localparam int SUM_W = 14;
    localparam logic [OFS_W-1:0] OFS_DEFAULT = 12'h007;
    localparam int OFS_LO_W = 8;
    localparam logic [DATA_W-1:0] QOUT_RESET = 9'h000;
    localparam int SYNC_STAGES = 2;
    // pin vector positions after the synchroniser
    localparam int PIN_RST_N = 0;
    localparam int PIN_WCLK = 1;
    localparam int PIN_RCLK = 2;
    localparam int PIN_WRITE_ENABLE_PRIMARY_N_N = 3;
    localparam int PIN_SECOND_WRITE_ENABLE_OR_OFFSET_LOAD = 4;
    localparam int PIN_RENA_N = 5;
    localparam int PIN_RENB_N = 6;
    localparam int PIN_OE_N = 7;
    localparam int PIN_DATA = 8;
    localparam int PIN_W = PIN_DATA + DATA_W;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_EMPTY_OFS = 8'h08;
    localparam logic [7:0] ADDR_FULL_OFS = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    // status field positions
    localparam int ST_FULL_N = 0;
    localparam int ST_AFULL_N = 1;
    localparam int ST_AEMPTY_N = 2;
    localparam int ST_EMPTY_N = 3;
    localparam int ST_DEPTH_MODE = 4;
    localparam int ST_IN_RESET = 5;
    localparam int CTRL_FLUSH = 0;
    localparam logic CTRL_RESET = 1'b0;
    // offset register walk order
    typedef enum logic [1:0] {
        OFS_EMPTY_LO = 2'b00,
        OFS_EMPTY_HI = 2'b01,
        OFS_FULL_LO = 2'b10,
        OFS_FULL_HI = 2'b11
    } ffs_ofs_sel_t;
endpackage : ffs_pkg
`default_nettype wire

// *** ffs_sync.sv ***
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ffs_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ffs_sync
`default_nettype wire

// *** ffs_mem.sv ***
// flip-flop storage array with one write and one read index
`timescale 1ns/1ps
`default_nettype none
module ffs_mem #(
    parameter int W = 9,
    parameter int ADDR_W = 6
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem_reg [2**ADDR_W];

    // store one word per accepted write
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // word under the read index
    assign rd_data = mem_reg[rd_addr];
endmodule : ffs_mem
`default_nettype wire

// *** ffs_top.sv ***
// dual-clock 9-bit fifo with status flags, offset registers and apb view
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ffs_top
    import ffs_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_n,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic [ffs_pkg::DATA_W-1:0] write_data_bus,
    input wire logic write_enable_primary_n,
    input wire logic second_write_enable_or_offset_load,
    input wire logic read_enable_a_n,
    input wire logic read_enable_b_n,
    input wire logic output_enable_n,
    output logic [ffs_pkg::DATA_W-1:0] read_data_bus,
    output logic read_data_bus_oe,
    output logic full_flag_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n,
    output logic empty_flag_n
);
    import ffs_pkg::*;

    // pointers carry one extra bit so full and empty differ
    localparam int CNT_W = ADDR_W + 1;
    localparam logic [CNT_W-1:0] DEPTH = CNT_W'(2**ADDR_W);

    // synchronised pins, pointers, offsets and bus decode
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic wclk_d_reg;
    logic rclk_d_reg;
    logic wclk_rise;
    logic rclk_rise;
    logic dev_rst;
    logic depth_mode_reg;
    logic flush_reg;
    logic [CNT_W-1:0] wptr_reg;
    logic [CNT_W-1:0] rptr_reg;
    logic [CNT_W-1:0] wptr_next;
    logic [CNT_W-1:0] rptr_next;
    logic [CNT_W-1:0] cnt_w;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_w_after;
    logic [CNT_W-1:0] cnt_r_after;
    logic [OFS_W-1:0] empty_ofs_reg;
    logic [OFS_W-1:0] full_ofs_reg;
    ffs_ofs_sel_t wsel_reg;
    ffs_ofs_sel_t rsel_reg;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] ofs_q;
    logic load_sel;
    logic fifo_wr_req;
    logic ofs_wr_req;
    logic both_ren;
    logic wr_ok;
    logic rd_ok;
    logic ofs_wr;
    logic ofs_rd;
    logic [SUM_W-1:0] af_sum;
    logic [SUM_W-1:0] ae_cnt;
    logic apb_hit;
    logic apb_wr;
    logic [31:0] rd_word;
    logic rd_valid;

    // pin levels gathered for one synchroniser
    assign pin_raw[PIN_RST_N] = reset_n;
    assign pin_raw[PIN_WCLK] = write_clk;
    assign pin_raw[PIN_RCLK] = read_clk;
    assign pin_raw[PIN_WRITE_ENABLE_PRIMARY_N_N] = write_enable_primary_n;
    assign pin_raw[PIN_SECOND_WRITE_ENABLE_OR_OFFSET_LOAD] = second_write_enable_or_offset_load;
    assign pin_raw[PIN_RENA_N] = read_enable_a_n;
    assign pin_raw[PIN_RENB_N] = read_enable_b_n;
    assign pin_raw[PIN_OE_N] = output_enable_n;
    assign pin_raw[PIN_DATA +: DATA_W] = write_data_bus;

    ffs_sync #(
        .W(PIN_W)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // edge detectors on the synchronised pin clocks
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wclk_d_reg <= 1'b0;
            rclk_d_reg <= 1'b0;
        end else begin
            wclk_d_reg <= pin_s[PIN_WCLK];
            rclk_d_reg <= pin_s[PIN_RCLK];
        end
    end

    // one-cycle pulse on each pin clock rise
    assign wclk_rise = pin_s[PIN_WCLK] & ~wclk_d_reg;
    assign rclk_rise = pin_s[PIN_RCLK] & ~rclk_d_reg;
    // device reset overrides any clock edge seen meanwhile
    assign dev_rst = sys_rst | ~pin_s[PIN_RST_N] | flush_reg;

    // role of the dual-purpose pin caught while reset is held
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            depth_mode_reg <= 1'b0;
        end else if (dev_rst) begin
            depth_mode_reg <= pin_s[PIN_SECOND_WRITE_ENABLE_OR_OFFSET_LOAD];
        end
    end

    // write and read qualification
    assign load_sel = ~depth_mode_reg & ~pin_s[PIN_SECOND_WRITE_ENABLE_OR_OFFSET_LOAD];
    assign fifo_wr_req = ~pin_s[PIN_WRITE_ENABLE_PRIMARY_N_N] & pin_s[PIN_SECOND_WRITE_ENABLE_OR_OFFSET_LOAD];
    assign ofs_wr_req = load_sel & ~pin_s[PIN_WRITE_ENABLE_PRIMARY_N_N];
    assign both_ren = ~pin_s[PIN_RENA_N] & ~pin_s[PIN_RENB_N];
    // counts from pointers sampled at the flag's own edge
    assign cnt_w = wptr_reg - rptr_reg;
    assign cnt_r = wptr_reg - rptr_reg;
    // accesses qualified by the synchronised clock edges
    assign wr_ok = wclk_rise & fifo_wr_req & (cnt_w != DEPTH);
    assign rd_ok = rclk_rise & both_ren & ~load_sel & (cnt_r != '0);
    assign ofs_wr = wclk_rise & ofs_wr_req;
    assign ofs_rd = rclk_rise & both_ren & load_sel;
    // next pointers and counts seen after this edge's access
    assign wptr_next = wptr_reg + CNT_W'(wr_ok);
    assign rptr_next = rptr_reg + CNT_W'(rd_ok);
    assign cnt_w_after = wptr_next - rptr_reg;
    assign cnt_r_after = wptr_reg - rptr_next;
    // almost-full threshold sum, wide enough for any offset
    assign af_sum = SUM_W'(cnt_w) + SUM_W'(full_ofs_reg);
    // count widened to the sum width for the compare against the empty offset
    assign ae_cnt = SUM_W'(cnt_r);

    // storage written at the write pointer, read at the read pointer
    ffs_mem #(
        .W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .mclk(mclk),
        .wr_en(wr_ok),
        .wr_addr(wptr_reg[ADDR_W-1:0]),
        .wr_data(pin_s[PIN_DATA +: DATA_W]),
        .rd_addr(rptr_reg[ADDR_W-1:0]),
        .rd_data(mem_q)
    );

    // pointers return to the first location in reset
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
        end
    end

    // offset registers loaded in walk order
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            empty_ofs_reg <= OFS_DEFAULT;
            full_ofs_reg <= OFS_DEFAULT;
            wsel_reg <= OFS_EMPTY_LO;
        end else if (ofs_wr) begin
            unique case (wsel_reg)
                OFS_EMPTY_LO: begin
                    empty_ofs_reg[OFS_LO_W-1:0] <= pin_s[PIN_DATA +: OFS_LO_W];
                end
                OFS_EMPTY_HI: begin
                    empty_ofs_reg[OFS_W-1:OFS_LO_W] <=
                        pin_s[PIN_DATA +: (OFS_W - OFS_LO_W)];
                end
                OFS_FULL_LO: begin
                    full_ofs_reg[OFS_LO_W-1:0] <= pin_s[PIN_DATA +: OFS_LO_W];
                end
                OFS_FULL_HI: begin
                    full_ofs_reg[OFS_W-1:OFS_LO_W] <=
                        pin_s[PIN_DATA +: (OFS_W - OFS_LO_W)];
                end
            endcase
            wsel_reg <= ffs_ofs_sel_t'(wsel_reg + 2'b01);
        end
    end

    // offset readback walk on the read side
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            rsel_reg <= OFS_EMPTY_LO;
        end else if (ofs_rd) begin
            rsel_reg <= ffs_ofs_sel_t'(rsel_reg + 2'b01);
        end
    end

    // offset byte selected for readback
    always_comb begin
        ofs_q = '0;
        unique case (rsel_reg)
            OFS_EMPTY_LO: ofs_q = DATA_W'(empty_ofs_reg[OFS_LO_W-1:0]);
            OFS_EMPTY_HI: ofs_q = DATA_W'(empty_ofs_reg[OFS_W-1:OFS_LO_W]);
            OFS_FULL_LO: ofs_q = DATA_W'(full_ofs_reg[OFS_LO_W-1:0]);
            OFS_FULL_HI: ofs_q = DATA_W'(full_ofs_reg[OFS_W-1:OFS_LO_W]);
        endcase
    end

    // output register and its drive enable
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            read_data_bus <= QOUT_RESET;
        end else if (rd_ok) begin
            read_data_bus <= mem_q;
        end else if (ofs_rd) begin
            read_data_bus <= ofs_q;
        end
    end

    // drive enable follows its pin through the synchroniser
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            read_data_bus_oe <= 1'b0;
        end else begin
            read_data_bus_oe <= ~pin_s[PIN_OE_N];
        end
    end

    // write side flags
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else if (wclk_rise) begin
            full_flag_n <= (cnt_w_after != DEPTH);
            // taken before this edge's write: a write here lands one past
            almost_full_flag_n <= (af_sum < SUM_W'(DEPTH));
        end
    end

    // read side flags
    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else if (rclk_rise) begin
            empty_flag_n <= (cnt_r_after != '0);
            // taken before this edge's read: a read here lands one below
            almost_empty_flag_n <= (ae_cnt > SUM_W'(empty_ofs_reg));
        end
    end

    // apb slave with one wait state
    assign apb_hit = psel & penable & pready;
    assign apb_wr = apb_hit & pwrite & (paddr == ADDR_CONTROL);

    // ready pulses in the second access cycle only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // control register: flush holds the fifo in reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flush_reg <= CTRL_RESET;
        end else if (apb_wr) begin
            flush_reg <= pwdata[CTRL_FLUSH];
        end
    end

    // read decode
    always_comb begin
        rd_word = '0;
        rd_valid = 1'b1;
        unique case (paddr)
            ADDR_STATUS: begin
                rd_word[ST_FULL_N] = full_flag_n;
                rd_word[ST_AFULL_N] = almost_full_flag_n;
                rd_word[ST_AEMPTY_N] = almost_empty_flag_n;
                rd_word[ST_EMPTY_N] = empty_flag_n;
                rd_word[ST_DEPTH_MODE] = depth_mode_reg;
                rd_word[ST_IN_RESET] = dev_rst;
            end
            ADDR_COUNT: rd_word = 32'(cnt_w);
            ADDR_EMPTY_OFS: rd_word = 32'(empty_ofs_reg);
            ADDR_FULL_OFS: rd_word = 32'(full_ofs_reg);
            ADDR_CONTROL: rd_word[CTRL_FLUSH] = flush_reg;
            default: rd_valid = 1'b0;
        endcase
    end

    // answer registered with the ready
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= ~rd_valid;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end
endmodule : ffs_top
`default_nettype wire

// *** ffs_top_asserts.sv ***
// concurrent checks on the fifo flag block pins
`timescale 1ns/1ps
`default_nettype none
module ffs_top_asserts
    import ffs_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic read_enable_a_n,
    input wire logic read_enable_b_n,
    input wire logic output_enable_n,
    input wire logic [ffs_pkg::DATA_W-1:0] read_data_bus,
    input wire logic read_data_bus_oe,
    input wire logic full_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic empty_flag_n
);
    import ffs_pkg::*;
    // one domain: system clock, system reset
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // write side flags fall only behind a write clock rise
    a_full_wclk: assert property ($fell(full_flag_n) |-> $past(write_clk, 2))
        else $error("full flag fell without write clock");
    a_afull_wclk: assert property ($fell(almost_full_flag_n) |-> $past(write_clk, 2))
        else $error("almost full fell without write clock");
    // read side flags rise only behind a read clock rise
    a_empty_rclk: assert property ($rose(empty_flag_n) |-> $past(read_clk, 2))
        else $error("empty flag rose without read clock");
    a_aempty_rclk: assert property ($rose(almost_empty_flag_n) |-> $past(read_clk, 2))
        else $error("almost empty rose without read clock");
    // flag pairs at the two ends
    a_full_pair: assert property (!full_flag_n |-> !almost_full_flag_n)
        else $error("full without almost full");
    a_empty_pair: assert property (!empty_flag_n |-> !almost_empty_flag_n)
        else $error("empty without almost empty");
    // output register takes a nonzero value only on an enabled read edge
    a_rdata_hold: assert property (
        $changed(read_data_bus) && read_data_bus != '0 |->
            $past(read_clk, 2) && !$past(read_enable_a_n, 2) && !$past(read_enable_b_n, 2))
        else $error("read data changed without enabled read");
    a_oe_follow: assert property (
        !$past(sys_rst, 4) |-> read_data_bus_oe == !$past(output_enable_n, 3))
        else $error("output drive does not follow enable pin");
    a_dev_reset: assert property (
        !reset_n [*4] |=> full_flag_n && almost_full_flag_n && !empty_flag_n
            && !almost_empty_flag_n && read_data_bus == '0)
        else $error("flags or data wrong in device reset");
endmodule : ffs_top_asserts
`default_nettype wire

// *** ffs_pins_model.sv ***
// writing and reading system logic driving the fifo pins
`timescale 1ns/1ps
`default_nettype none
module ffs_pins_model (
    input wire logic mclk,
    output logic write_clk,
    output logic read_clk,
    output logic [ffs_pkg::DATA_W-1:0] write_data_bus,
    output logic write_enable_primary_n,
    output logic read_enable_a_n,
    output logic read_enable_b_n
);
    import ffs_pkg::*;
    // idle levels; pin clocks stand still between frames
    initial begin
        write_clk = 1'b0;
        read_clk = 1'b0;
        write_data_bus = '0;
        write_enable_primary_n = 1'b1;
        read_enable_a_n = 1'b1;
        read_enable_b_n = 1'b1;
    end
    // one write frame, data inverted once released
    task automatic wr(input logic [DATA_W-1:0] d, input logic w_n);
        write_data_bus <= d;
        write_enable_primary_n <= w_n;
        @(posedge mclk) write_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        write_clk <= 1'b0;
        write_data_bus <= ~d;
        write_enable_primary_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : wr
    // one read frame, both enables held across the rise
    task automatic rd(input logic a_n, input logic b_n);
        read_enable_a_n <= a_n;
        read_enable_b_n <= b_n;
        @(posedge mclk) read_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        read_clk <= 1'b0;
        read_enable_a_n <= 1'b1;
        read_enable_b_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : rd
endmodule : ffs_pins_model
`default_nettype wire

// *** clocked_fifo_status_flags_test.sv ***
// self-checking bench for the fifo status flag block
`timescale 1ns/1ps
`default_nettype none
module clocked_fifo_status_flags_test;
    import ffs_pkg::*;
    localparam int DEPTH = 64;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, reset_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic write_clk, read_clk, write_enable_primary_n, second_write_enable_or_offset_load;
    logic read_enable_a_n, read_enable_b_n, output_enable_n, read_data_bus_oe;
    logic full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n;
    logic [DATA_W-1:0] write_data_bus, read_data_bus;
    logic [DATA_W-1:0] hi_read_data_bus;
    logic hi_full_flag_n, hi_empty_flag_n;
    int errors = 0;
    int tests_run = 0;
    ffs_top #(.ADDR_W(6)) i_ffs_top (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .reset_n, .write_clk, .read_clk,
        .write_data_bus, .write_enable_primary_n, .second_write_enable_or_offset_load,
        .read_enable_a_n, .read_enable_b_n, .output_enable_n, .read_data_bus,
        .read_data_bus_oe, .full_flag_n, .almost_full_flag_n, .almost_empty_flag_n,
        .empty_flag_n);
    ffs_pins_model i_ffs_pins_model (.mclk, .write_clk, .read_clk, .write_data_bus,
        .write_enable_primary_n, .read_enable_a_n, .read_enable_b_n);
    // upper lane of a width-expanded pair: same controls, inverted data
    ffs_top #(.ADDR_W(6)) i_ffs_top_hi (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata(), .pready(), .pslverr(), .reset_n, .write_clk, .read_clk,
        .write_data_bus(~write_data_bus), .write_enable_primary_n,
        .second_write_enable_or_offset_load, .read_enable_a_n, .read_enable_b_n,
        .output_enable_n, .read_data_bus(hi_read_data_bus), .read_data_bus_oe(),
        .full_flag_n(hi_full_flag_n), .almost_full_flag_n(), .almost_empty_flag_n(),
        .empty_flag_n(hi_empty_flag_n));
    // 25 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk) penable <= 1'b1;
        do @(posedge mclk) n++; while (pready !== 1'b1);
        chk("wait states", n, 2);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, '0, q, e);
        chk("prdata", q, exp);
        chk("pslverr", e, 1'b0);
    endtask : rreg
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        reset_n <= 1'b0;
        i_ffs_pins_model.wr(9'h1AA, 1'b0);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("flags", {full_flag_n, almost_full_flag_n, almost_empty_flag_n,
            empty_flag_n}, 4'hC);
        chk("qout", read_data_bus, 9'h000);
        rreg(ADDR_COUNT, 32'h0);
        rreg(ADDR_STATUS, 32'h3);
        rreg(ADDR_EMPTY_OFS, 32'h7);
        rreg(ADDR_FULL_OFS, 32'h7);
        apb(8'h20, 1'b1, 32'hFFFF_FFFF, q, e);
        chk("unmapped", e, 1'b1);
        apb(ADDR_CONTROL, 1'b1, 32'h1, q, e);
        rreg(ADDR_STATUS, 32'h23);
        apb(ADDR_CONTROL, 1'b1, 32'h0, q, e);
        output_enable_n <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("oe", read_data_bus_oe, 1'b0);
        output_enable_n <= 1'b0;
    endtask : t_reset
    task automatic t_offsets();
        logic [DATA_W-1:0] ofs [5] = '{9'h003, 9'h000, 9'h005, 9'h000, 9'h002};
        foreach (ofs[i]) i_ffs_pins_model.wr(ofs[i], 1'b0);
        rreg(ADDR_EMPTY_OFS, 32'h2);
        rreg(ADDR_FULL_OFS, 32'h5);
        i_ffs_pins_model.rd(1'b0, 1'b0);
        chk("ofs read", read_data_bus, 9'h002);
        second_write_enable_or_offset_load <= 1'b1;
    endtask : t_offsets
    task automatic t_fill_drain();
        for (int k = 1; k <= DEPTH; k++) begin
            i_ffs_pins_model.wr(DATA_W'(k) ^ 9'h155, 1'b0);
            chk("full", full_flag_n, k != DEPTH);
            chk("wide full", full_flag_n & hi_full_flag_n, k != DEPTH);
            chk("afull", almost_full_flag_n, k - 1 < DEPTH - 5);
        end
        chk("empty", empty_flag_n, 1'b0);
        i_ffs_pins_model.wr(9'h0F0, 1'b0);
        rreg(ADDR_COUNT, DEPTH);
        i_ffs_pins_model.rd(1'b0, 1'b1);
        chk("held", read_data_bus, 9'h002);
        chk("empty", empty_flag_n, 1'b1);
        for (int j = 0; j < DEPTH; j++) begin
            i_ffs_pins_model.rd(1'b0, 1'b0);
            chk("data", read_data_bus, DATA_W'(j + 1) ^ 9'h155);
            chk("aempty", almost_empty_flag_n, DEPTH - j > 2);
            chk("empty", empty_flag_n, j != DEPTH - 1);
            chk("hi data", hi_read_data_bus, DATA_W'(j + 1) ^ 9'h0AA);
            chk("wide empty", empty_flag_n & hi_empty_flag_n, j != DEPTH - 1);
        end
        i_ffs_pins_model.rd(1'b0, 1'b0);
        chk("held", read_data_bus, 9'h040 ^ 9'h155);
        rreg(ADDR_COUNT, 32'h0);
    endtask : t_fill_drain
    task automatic t_depth();
        reset_n <= 1'b0; // load pin high: second write enable
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        rreg(ADDR_STATUS, 32'h13);
        rreg(ADDR_FULL_OFS, 32'h7);
        second_write_enable_or_offset_load <= 1'b0;
        i_ffs_pins_model.wr(9'h011, 1'b0);
        rreg(ADDR_COUNT, 32'h0);
        second_write_enable_or_offset_load <= 1'b1;
        i_ffs_pins_model.wr(9'h011, 1'b0);
        rreg(ADDR_COUNT, 32'h1);
    endtask : t_depth
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // reset, then the scenarios in turn
    initial begin
        sys_rst = 1'b1;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        reset_n = 1'b1;
        second_write_enable_or_offset_load = 1'b0;
        output_enable_n = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset();
        t_offsets();
        t_fill_drain();
        t_depth();
        tally_and_finish();
    end
    // hang guard, well beyond the expected run
    initial begin
        #800us;
        errors++;
        tally_and_finish();
    end
endmodule : clocked_fifo_status_flags_test
bind ffs_top ffs_top_asserts #(.ADDR_W(ADDR_W)) i_ffs_top_asserts (.mclk, .sys_rst, .reset_n,
    .write_clk, .read_clk, .read_enable_a_n, .read_enable_b_n, .output_enable_n,
    .read_data_bus, .read_data_bus_oe, .full_flag_n, .almost_full_flag_n,
    .almost_empty_flag_n, .empty_flag_n);
`default_nettype wire
